// ==== core/gdi_i2c_port.sv ====
// Two-wire target port in frame mode with code banks and refresh timing
`timescale 1ns/1ps
module gdi_i2c_port
  import gdi_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output wire logic                  sda_o,
  output      logic                  sda_oe,
  input  wire logic                  interface_mode_pin,
  input  wire logic                  address_select_pin,
  input  wire logic                  curve_select_pin,
  input  wire logic                  refresh_clk,
  output wire logic                  refresh_pin_o,
  output wire logic                  refresh_pin_oe,
  output      logic [NUM_CH*8-1:0]   channel_code
);

  gdi_state_type state_reg;
  logic [4:0]    sync1_reg;
  logic [4:0]    sync2_reg;
  logic          scl_d_reg;
  logic          sda_d_reg;
  logic [2:0]    bit_cnt_reg;
  logic [7:0]    shift_reg;
  logic [3:0]    idx_reg;
  logic          rw_reg;
  logic          ack_go_reg;
  logic          ack_phase_reg;
  logic [3:0]    frame_control_reg;
  logic          ctl_loaded_reg;
  logic [7:0]    bank_mem [2][NUM_CH];
  logic [7:0]    osc_cnt_reg;
  logic          osc_reg;
  logic          ext_tgl_reg;
  logic [2:0]    ext_sync_reg;
  logic [5:0]    lag_cnt_reg;
  logic          lag_busy_reg;

  logic          scl_s;
  logic          sda_s;
  logic          asel_s;
  logic          mode_s;
  logic          curve_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_evt;
  logic          stop_evt;
  logic [7:0]    full_byte;
  logic          byte_done;
  logic          wr_evt;
  logic [7:0]    rd_byte;
  logic          int_fall;
  logic          ext_fall;
  logic          ref_evt;
  logic          load_evt;

  // Pins cross into sys_clk through two flops; 10 MHz oversamples 400 kHz
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 5'h1B;
      sync2_reg <= 5'h1B;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else if (ce)
    begin
      sync1_reg <= {scl_i, sda_i, address_select_pin, interface_mode_pin, curve_select_pin};
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign {scl_s, sda_s, asel_s, mode_s, curve_s} = sync2_reg;

  // Bus conditions seen on synchronised lines
  assign scl_rise  = ce && scl_s && !scl_d_reg;
  assign scl_fall  = ce && !scl_s && scl_d_reg;
  assign start_evt = ce && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_evt  = ce && scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign full_byte = {shift_reg[6:0], sda_s};
  assign byte_done = scl_rise && (bit_cnt_reg == BIT_LAST) && !start_evt && !stop_evt && mode_s;
  assign wr_evt    = byte_done && (state_reg == ST_WDATA);
  assign rd_byte   = (idx_reg < 4'(NUM_CH)) ?
                     bank_mem[frame_control_reg[CTL_RB_BIT]][idx_reg] : CODE_RESET;
  assign sda_o     = 1'b0;

  // Protocol engine; the line is only ever pulled low, never driven high
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      idx_reg       <= IDX_CTL;
      rw_reg        <= 1'b0;
      ack_go_reg    <= 1'b0;
      ack_phase_reg <= 1'b0;
      sda_oe        <= 1'b0;
    end
    else if (ce)
    begin
      if (!mode_s)
      begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end
      else if (start_evt)
      begin
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 3'h0;
        ack_phase_reg <= 1'b0;
        sda_oe        <= 1'b0;
      end
      else if (stop_evt)
      begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_WDATA:
          begin
            if (scl_rise)
            begin
              shift_reg   <= full_byte;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == BIT_LAST)
              begin
                ack_phase_reg <= 1'b0;
                if (state_reg == ST_WDATA)
                begin
                  ack_go_reg <= (idx_reg <= IDX_WR_LAST);
                  state_reg  <= ST_ACK;
                end
                else if (gdi_addr_hit(full_byte, asel_s))
                begin
                  rw_reg     <= full_byte[0];
                  idx_reg    <= full_byte[0] ? IDX_CTL : IDX_WR_START;
                  ack_go_reg <= 1'b1;
                  state_reg  <= ST_ACK;
                end
                else
                begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              if (!ack_phase_reg)
              begin
                ack_phase_reg <= 1'b1;
                sda_oe        <= ack_go_reg;
              end
              else
              begin
                ack_phase_reg <= 1'b0;
                bit_cnt_reg   <= 3'h0;
                if (!ack_go_reg)
                begin
                  sda_oe    <= 1'b0;
                  state_reg <= ST_WAIT;
                end
                else if (rw_reg)
                begin
                  sda_oe    <= !rd_byte[7];
                  state_reg <= ST_RDATA;
                end
                else
                begin
                  sda_oe    <= 1'b0;
                  idx_reg   <= idx_reg + 4'h1;
                  state_reg <= ST_WDATA;
                end
              end
            end
          end
          ST_RDATA:
          begin
            if (scl_rise)
            begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == BIT_LAST)
              begin
                ack_phase_reg <= 1'b0;
                state_reg     <= ST_RACK;
              end
            end
            else if (scl_fall)
            begin
              sda_oe <= !rd_byte[BIT_LAST - bit_cnt_reg];
            end
          end
          ST_RACK:
          begin
            // Release for the master's acknowledge slot, then sample it
            if (scl_fall && !ack_phase_reg)
            begin
              sda_oe        <= 1'b0;
              ack_phase_reg <= 1'b1;
            end
            else if (scl_rise && ack_phase_reg)
            begin
              if (sda_s || idx_reg == IDX_RD_LAST)
                state_reg <= ST_WAIT;
              else
                idx_reg <= idx_reg + 4'h1;
            end
            else if (scl_fall && ack_phase_reg)
            begin
              ack_phase_reg <= 1'b0;
              bit_cnt_reg   <= 3'h0;
              sda_oe        <= !rd_byte[7];
              state_reg     <= ST_RDATA;
            end
          end
          ST_IDLE, ST_WAIT:
          begin
            sda_oe <= 1'b0;
          end
          default:
          begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Control byte is kept until the next write frame replaces it
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_control_reg <= CTL_RESET;
      ctl_loaded_reg    <= 1'b0;
    end
    else if (wr_evt && idx_reg == IDX_CTL)
    begin
      frame_control_reg <= full_byte[3:0];
      ctl_loaded_reg    <= 1'b1;
    end
  end

  // Code banks; a code lands in the bank named by the write bank bit
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int b = 0; b < 2; b++)
        for (int c = 0; c < NUM_CH; c++)
          bank_mem[b][c] <= CODE_RESET;
    end
    else if (wr_evt && idx_reg != IDX_CTL && idx_reg <= IDX_WR_LAST)
    begin
      bank_mem[frame_control_reg[CTL_WB_BIT]][idx_reg - 4'h1] <= full_byte;
    end
  end

  // Internal refresh oscillator, free running from sys_clk
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_cnt_reg <= 8'h00;
      osc_reg     <= 1'b0;
    end
    else if (ce)
    begin
      if (osc_cnt_reg == 8'(OSC_HALF_CYC - 1))
      begin
        osc_cnt_reg <= 8'h00;
        osc_reg     <= !osc_reg;
      end
      else
      begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
    end
  end

  assign int_fall = ce && osc_reg && (osc_cnt_reg == 8'(OSC_HALF_CYC - 1));

  // Pin stays released until software has chosen the internal clock source
  assign refresh_pin_o  = osc_reg;
  assign refresh_pin_oe = ctl_loaded_reg && !frame_control_reg[CTL_SRC_BIT];

  // External refresh clock domain: each falling edge flips a toggle
  always_ff @(negedge refresh_clk or negedge rstn)
  begin
    if (!rstn)
      ext_tgl_reg <= 1'b0;
    else
      ext_tgl_reg <= !ext_tgl_reg;
  end

  // Toggle crosses to sys_clk; the third flop serves edge detection
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ext_sync_reg <= 3'h0;
    else if (ce)
      ext_sync_reg <= {ext_sync_reg[1:0], ext_tgl_reg};
  end

  assign ext_fall = ce && (ext_sync_reg[2] ^ ext_sync_reg[1]);
  assign ref_evt  = frame_control_reg[CTL_SRC_BIT] ? ext_fall : int_fall;

  // Optional lag; edges during a pending lag are dropped so a fast clock cannot starve the load
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lag_cnt_reg  <= 6'h00;
      lag_busy_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (ref_evt && frame_control_reg[CTL_LAG_BIT] && !lag_busy_reg)
      begin
        lag_cnt_reg  <= 6'(LAG_CYC - 1);
        lag_busy_reg <= 1'b1;
      end
      else if (lag_busy_reg)
      begin
        lag_busy_reg <= (lag_cnt_reg != 6'h00);
        lag_cnt_reg  <= lag_cnt_reg - 6'h01;
      end
    end
  end

  assign load_evt = ce && ((ref_evt && !frame_control_reg[CTL_LAG_BIT]) ||
                           (lag_busy_reg && lag_cnt_reg == 6'h00));

  // Outputs follow the bank chosen by the curve pin at each refresh
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          channel_code[g*8 +: 8] <= CODE_RESET;
        else if (load_evt)
          channel_code[g*8 +: 8] <= bank_mem[curve_s][g];
      end
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_MODE_LOW: assert property (ce && !mode_s |=> state_reg == ST_IDLE)
    else $error("register mode did not idle the port");
  AST_ADDR_MISS: assert property (byte_done && state_reg == ST_ADDR
    && !gdi_addr_hit(full_byte, asel_s) |=> state_reg == ST_IDLE ##1 !sda_oe)
    else $error("foreign address was answered");
  AST_DIR: assert property (byte_done && state_reg == ST_ADDR && gdi_addr_hit(full_byte, asel_s)
    |=> rw_reg == $past(full_byte[0]) && state_reg == ST_ACK)
    else $error("direction bit not captured");
  AST_CODE_STORE: assert property (wr_evt && idx_reg != IDX_CTL && idx_reg <= IDX_WR_LAST
    |=> bank_mem[frame_control_reg[CTL_WB_BIT]][$past(idx_reg) - 4'h1] == $past(full_byte))
    else $error("code byte stored in wrong place");
  AST_CTL_KEEP: assert property (!(wr_evt && idx_reg == IDX_CTL)
    |=> $stable(frame_control_reg))
    else $error("control byte changed outside its slot");
  AST_NO_EXTRA_ACK: assert property (state_reg == ST_ACK && !ack_go_reg |-> !sda_oe)
    else $error("byte past the last code acknowledged");
  AST_WAIT_RELEASE: assert property (state_reg == ST_WAIT |-> !sda_oe)
    else $error("data line held after transfer end");
  AST_PIN_HIZ: assert property (!ctl_loaded_reg || frame_control_reg[CTL_SRC_BIT]
    |-> !refresh_pin_oe)
    else $error("refresh pin driven while released");
  AST_LAG: assert property (ref_evt && frame_control_reg[CTL_LAG_BIT] && !lag_busy_reg
    ##1 ce [*8] |-> !load_evt)
    else $error("lag shorter than expected");
  AST_REFRESH: assert property (load_evt
    |=> channel_code[7:0] == $past(bank_mem[curve_s][0]))
    else $error("output not loaded from selected bank");

endmodule : gdi_i2c_port

// ==== core/gdi_pkg.sv ====
// Constants and types shared by the gamma DAC serial target port
package gdi_pkg;
  localparam int          SYS_CLK_MHZ  = 10;
  localparam int          NUM_CH       = 14;
  localparam int          SCL_MAX_KHZ  = 400;
  localparam logic [5:0]  ADDR_FIXED   = 6'h3A;
  localparam int          CTL_LAG_BIT  = 0;
  localparam int          CTL_WB_BIT   = 1;
  localparam int          CTL_RB_BIT   = 2;
  localparam int          CTL_SRC_BIT  = 3;
  localparam logic [3:0]  CTL_RESET    = 4'h0;
  localparam logic [7:0]  CODE_RESET   = 8'h00;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  IDX_CTL      = 4'h0;
  localparam logic [3:0]  IDX_WR_LAST  = 4'hE;
  localparam logic [3:0]  IDX_RD_LAST  = 4'hD;
  localparam logic [3:0]  IDX_WR_START = 4'hF;
  localparam int          OSC_HZ       = 20000;
  localparam int          OSC_HALF_CYC = SYS_CLK_MHZ * 1000000 / (2 * OSC_HZ);
  localparam int          LAG_NS       = 3500;
  localparam int          LAG_CYC      = (LAG_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_WAIT
  } gdi_state_type;

  // Address byte hits this target: fixed upper six bits plus select pin
  function automatic logic gdi_addr_hit(input logic [7:0] b, input logic sel);
    gdi_addr_hit = (b[7:2] == ADDR_FIXED) && (b[1] == sel);
  endfunction : gdi_addr_hit
endpackage : gdi_pkg

// ==== sim/gdi_bus_master.sv ====
// Two-wire bus master model issuing frame-mode writes and reads
`timescale 1ns/1ps
module gdi_bus_master
  import gdi_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sda_dev_oe,
  output      logic scl,
  output wire logic sda_line
);
  localparam int HALF = 10; // 1 us phases keep the bus under 500 kHz
  logic pull_low = 1'b0;

  // Open-drain line with pull-up: a released line reads high, never a stale value
  assign sda_line = !(pull_low || sda_dev_oe);
  initial scl = 1'b1;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  // Data moves well after the clock fall so the target never mistakes it for start or stop
  task automatic clock_bit(input logic b, output logic seen);
    wait_cyc(3);
    pull_low = !b;
    wait_cyc(HALF);
    scl = 1'b1;
    wait_cyc(HALF);
    seen = sda_line;
    scl = 1'b0;
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], seen);
    clock_bit(1'b1, seen);
    ack = !seen;
  endtask : send_byte

  task automatic frame_edge(input logic opening);
    wait_cyc(3);
    pull_low = opening ? 1'b0 : 1'b1;
    wait_cyc(HALF);
    scl = 1'b1;
    wait_cyc(HALF);
    pull_low = opening;
    wait_cyc(HALF);
    if (opening)
      scl = 1'b0;
  endtask : frame_edge

  // Address, control, then the codes in channel order
  task automatic write_frame(input logic [6:0] addr, input logic [7:0] ctl, input logic [7:0] codes [0:15],
                             input int n, output logic [16:0] acks);
    logic a;
    acks = '0;
    frame_edge(1'b1);
    send_byte({addr, 1'b0}, a);
    acks[0] = a;
    if (a)
    begin
      send_byte(ctl, a);
      acks[1] = a;
      for (int k = 0; k < n; k++)
      begin
        send_byte(codes[k], a);
        acks[k + 2] = a;
      end
    end
    frame_edge(1'b0);
  endtask : write_frame

  // Acknowledge codes one to thirteen, refuse the fourteenth
  task automatic read_frame(input logic [6:0] addr, output logic ack, output logic [7:0] got [0:13]);
    logic seen;
    frame_edge(1'b1);
    send_byte({addr, 1'b1}, ack);
    for (int k = 0; k < 14; k++)
    begin
      got[k] = 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
        if (ack)
          clock_bit(1'b1, seen);
        got[k][i] = seen;
      end
      if (ack)
        clock_bit(k == 13, seen);
    end
    frame_edge(1'b0);
  endtask : read_frame
endmodule : gdi_bus_master

// ==== sim/testbench.sv ====
// Self-checking bench for the frame-mode serial target port
`timescale 1ns/1ps
module testbench;
  import gdi_pkg::*;
  typedef struct packed {logic asel; logic [6:0] addr; logic [7:0] ctl; logic hit;} gdi_row_type;

  logic          sys_clk = 1'b0;
  logic          refresh_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          interface_mode_pin = 1'b1;
  logic          address_select_pin = 1'b0;
  logic          curve_select_pin = 1'b0;
  logic          scl;
  wire logic     sda_line;
  logic          sda_oe;
  logic          refresh_pin_oe;
  logic          refresh_pin_o;
  logic [111:0]  channel_code;
  logic [7:0]    bank [0:1][0:13];
  logic [7:0]    ctl_q;
  logic          ctl_set;
  int            n_mismatch = 0;
  int            comparisons = 0;
  int            cycles = 0;
  gdi_row_type   rows [0:5] = '{'{1'b0, 7'h74, 8'h00, 1'b1}, '{1'b1, 7'h75, 8'hF6, 1'b1},
    '{1'b1, 7'h74, 8'h02, 1'b0}, '{1'b0, 7'h75, 8'h02, 1'b0}, '{1'b0, 7'h74, 8'h04, 1'b1},
    '{1'b1, 7'h75, 8'h0B, 1'b1}};

  gdi_i2c_port u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .scl_i(scl), .sda_i(sda_line), .sda_o(),
    .sda_oe(sda_oe), .interface_mode_pin(interface_mode_pin), .address_select_pin(address_select_pin),
    .curve_select_pin(curve_select_pin), .refresh_clk(refresh_clk), .refresh_pin_o(refresh_pin_o),
    .refresh_pin_oe(refresh_pin_oe), .channel_code(channel_code));
  gdi_bus_master u_mst (.sys_clk(sys_clk), .sda_dev_oe(sda_oe), .scl(scl), .sda_line(sda_line));

  // Clocks: system at 100 ns, external refresh at 6 ns with an offset phase
  always #50 sys_clk = ~sys_clk;
  initial
  begin
    #1.3;
    forever #3 refresh_clk = ~refresh_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Ceiling well above the roughly 53000 cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      $display("[ERR] %0t run timed out", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [111:0] seen, input logic [111:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic [111:0] bank_image(input logic b);
    for (int k = 0; k < NUM_CH; k++)
      bank_image[k*8 +: 8] = bank[b][k];
  endfunction : bank_image

  task automatic do_reset;
    @(posedge sys_clk);
    #1;
    rstn = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    check(channel_code, 112'h0, "codes in reset");
    check(112'({sda_oe, refresh_pin_oe, refresh_pin_o}), 112'h0, "pins in reset");
    rstn = 1'b1;
    bank = '{default: 8'h00};
    ctl_q = 8'h00;
    ctl_set = 1'b0;
    repeat (4) @(posedge sys_clk);
    $display("reset test done");
  endtask : do_reset

  // Optional write frame, then a full read-back and an output refresh check
  task automatic xfer(input logic asel, input logic [6:0] addr, input logic [7:0] ctl, input int n,
                      input logic [16:0] exp_acks, input int r);
    logic [7:0]   codes [0:15];
    logic [7:0]   got [0:13];
    logic [16:0]  acks;
    logic         ok;
    logic [111:0] rd;
    @(posedge sys_clk);
    #1;
    address_select_pin = asel;
    curve_select_pin = r[0];
    for (int k = 0; k < 16; k++)
      codes[k] = 8'(r * 16 + k + 1);
    if (n > 0)
    begin
      u_mst.write_frame(addr, ctl, codes, n, acks);
      check(112'(acks), 112'(exp_acks), "write acks");
      if (exp_acks[1])
      begin
        ctl_q = ctl;
        ctl_set = 1'b1;
      end
      for (int k = 0; k < NUM_CH; k++)
        if (exp_acks[k + 2])
          bank[ctl_q[CTL_WB_BIT]][k] = codes[k];
    end
    u_mst.read_frame({ADDR_FIXED, asel}, ok, got);
    for (int k = 0; k < NUM_CH; k++)
      rd[k*8 +: 8] = got[k];
    check(112'(ok), 112'h1, "read address ack");
    check(rd, bank_image(ctl_q[CTL_RB_BIT]), "read codes");
    check(112'(refresh_pin_oe), 112'(ctl_set && !ctl_q[CTL_SRC_BIT]), "refresh pin drive");
    repeat (700) @(posedge sys_clk);
    check(channel_code, bank_image(r[0]), "channel outputs");
    $display("test %0d done", r);
  endtask : xfer

  // Table rows first, then extra bytes, register mode and a reset in mid-run
  initial
  begin : main_seq
    logic [7:0]  codes [0:15];
    logic [16:0] acks;
    do_reset();
    for (int r = 0; r < 6; r++)
      xfer(rows[r].asel, rows[r].addr, rows[r].ctl, 14, rows[r].hit ? 17'h0FFFF : 17'h00000, r);
    xfer(1'b0, 7'h74, 8'h00, 15, 17'h0FFFF, 6);
    @(posedge sys_clk);
    #1;
    interface_mode_pin = 1'b0;
    codes = '{default: 8'hA5};
    u_mst.write_frame(7'h74, 8'h02, codes, 14, acks);
    check(112'(acks), 112'h0, "register mode acks");
    $display("register mode test done");
    interface_mode_pin = 1'b1;
    xfer(1'b0, 7'h74, 8'h00, 0, 17'h0, 7);
    do_reset();
    xfer(1'b0, 7'h74, 8'h00, 0, 17'h0, 8);
    tally_and_finish();
  end
endmodule : testbench
